// ==== rtl/estop_defs.svh ====
// Constant definitions for the emergency stop brake sequencer
`ifndef ESTOP_DEFS_SVH
`define ESTOP_DEFS_SVH
// Clock period in picoseconds (200 MHz)
`define ESTOP_CLK_PERIOD_PS 5000
// Default counter width for delays and timeouts
`define ESTOP_CNT_W 32
// Default speed word width
`define ESTOP_SPEED_W 16
// Cycles of the delay counter that stand for one delay tick
`define ESTOP_TICK_CYCLES 1
`endif

// ==== rtl/estop_pkg.sv ====
// Package of types for the emergency stop brake sequencer
package estop_pkg;
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000, // Waiting for a stop request
		ST_RAMP    = 3'b001, // Drive ramping, speed watched
		ST_EXTRA   = 3'b010, // Extra delay before brake and torque off
		ST_BRAKE   = 3'b011, // Brake on, torque off maybe pending
		ST_DONE    = 3'b100  // Stop completed, waiting for acknowledge
	} seq_state_t;
	// Monitoring variant
	typedef enum logic {
		MODE_TIME = 1'b0, // Stop timeout monitoring
		MODE_RAMP = 1'b1  // Deceleration ramp monitoring
	} mon_mode_t;
endpackage : estop_pkg

// ==== rtl/estop_seq.sv ====
// Emergency stop sequencer with speed limit activated brake and torque off
// Contract
// - Time mode: request starts timeout, stop active
// - Delay zero or positive: brake, torque together
// - Negative delay: brake now, torque later
// - Torque off flag follows actual torque off
// - Optional extra delay before brake activation
// - Timeout expiry forces torque off anyway
// - Time mode: zero speed means completed
// - Acknowledge only when completed and released
// - Acknowledge clears outputs, drive may modulate
// - Ramp mode: monitor limits after response time
// - Ramp mode: stop monitoring below brake speed
// - Ramp mode: limit hit forces torque off
// - Ramp mode: time-to-zero expiry means completed
`include "estop_defs.svh"
module estop_seq #(
	parameter int SPEED_W = `ESTOP_SPEED_W,
	parameter int CNT_W   = `ESTOP_CNT_W
) (
	// Clock and reset
	input  wire logic               CLK,
	input  wire logic               SRST,
	// Stop request and acknowledge
	input  wire logic               STOP_REQUEST,
	input  wire logic               ACKNOWLEDGE,
	// Configuration
	input  wire logic               RAMP_MODE,
	input  wire logic [SPEED_W-1:0] BRAKE_SPEED_LIMIT,
	input  wire logic [SPEED_W-1:0] ZERO_SPEED_LIMIT,
	input  wire logic [CNT_W-1:0]   STOP_TIMEOUT,
	input  wire logic [CNT_W-1:0]   RESPONSE_TIME,
	input  wire logic [CNT_W-1:0]   EXTRA_ACTIVATION_DELAY,
	input  wire logic               BRAKE_DELAY_NEGATIVE,
	input  wire logic [CNT_W-1:0]   BRAKE_TO_TORQUE_OFF_DELAY,
	input  wire logic [CNT_W-1:0]   BRAKE_TIME_TO_ZERO,
	// Speed and ramp limits
	input  wire logic [SPEED_W-1:0] MOTOR_SPEED,
	input  wire logic [SPEED_W-1:0] RAMP_LIMIT_LOW,
	input  wire logic [SPEED_W-1:0] RAMP_LIMIT_HIGH,
	// Drive side outputs
	output logic                    RAMP_DOWN,
	output logic                    MODULATION_ALLOWED,
	output logic                    BRAKE_CONTROL,
	output logic                    TORQUE_OFF,
	// Indications
	output logic                    STOP_ACTIVE_FLAG,
	output logic                    STOP_COMPLETED_FLAG,
	output logic                    TORQUE_OFF_ACTIVE_FLAG,
	output logic                    RAMP_MONITOR_ACTIVE,
	output logic                    ACK_ALLOWED
);
	// Refuse widths the comparators and timers cannot serve
	if (SPEED_W < 2 || SPEED_W > 32 || CNT_W < 2 || CNT_W > 32) begin : g_bad_width
		$error("estop_seq: unsupported width");
	end

	estop_pkg::seq_state_t state_q;  // Sequence state
	estop_pkg::seq_state_t state_d;  // Next state
	estop_pkg::mon_mode_t  mode_q;   // Mode latched at request
	logic torque_q;                  // Torque off active
	logic torque_d;                  // Next torque off
	logic brake_q;                   // Brake control active
	logic brake_d;                   // Next brake
	logic complete_q;                // Stop completed
	logic complete_d;                // Next completed
	logic ramp_q;                    // Drive ramping down
	logic mon_q;                     // Ramp monitoring active
	logic mon_d;                     // Next monitoring

	// Timer handshakes
	logic idle_clear;                // Clears every timer
	logic resp_exp;                  // Response time over
	logic tmo_exp;                   // Stop timeout over
	logic extra_exp;                 // Extra delay over
	logic extra_run;                 // Extra delay counting
	logic btd_exp;                   // Brake to torque delay over
	logic ttz_exp;                   // Time to zero over
	logic start_req;                 // Request accepted in idle
	logic below_brake;               // Speed under brake limit
	logic at_zero;                   // Speed at zero limit
	logic ramp_hit;                  // Speed outside the ramp limits while monitored
	logic brake_now;                 // Brake activating this cycle
	logic ack_ok;                    // Acknowledge accepted

	// Compare decoding
	function automatic logic below(input logic [SPEED_W-1:0] s,
		input logic [SPEED_W-1:0] lim);
		below = (s < lim);
	endfunction : below

	assign start_req   = (state_q == estop_pkg::ST_IDLE) && STOP_REQUEST;
	assign idle_clear  = ack_ok;
	assign below_brake = below(MOTOR_SPEED, BRAKE_SPEED_LIMIT);
	assign at_zero     = !below(ZERO_SPEED_LIMIT, MOTOR_SPEED);
	assign ramp_hit    = mon_q && (below(MOTOR_SPEED, RAMP_LIMIT_LOW) ||
		below(RAMP_LIMIT_HIGH, MOTOR_SPEED));
	assign ack_ok      = complete_q && !STOP_REQUEST && ACKNOWLEDGE;
	assign brake_now   = (state_q == estop_pkg::ST_EXTRA) && extra_exp;

	// Response time, after which the drive ramps
	estop_timer #(.W(CNT_W)) u_resp (
		.clk(CLK), .srst(SRST), .start(start_req), .clear(idle_clear),
		.length(RESPONSE_TIME), .running(), .expired(resp_exp)
	);
	// Stop timeout, time mode only
	estop_timer #(.W(CNT_W)) u_tmo (
		.clk(CLK), .srst(SRST),
		.start(start_req && !RAMP_MODE),
		.clear(idle_clear), .length(STOP_TIMEOUT), .running(), .expired(tmo_exp)
	);
	// Extra delay after the brake speed crossing
	estop_timer #(.W(CNT_W)) u_extra (
		.clk(CLK), .srst(SRST),
		.start((state_q == estop_pkg::ST_RAMP) && resp_exp && below_brake && !extra_run),
		.clear(idle_clear), .length(EXTRA_ACTIVATION_DELAY),
		.running(extra_run), .expired(extra_exp)
	);
	// Brake to torque off delay, negative setting only
	estop_timer #(.W(CNT_W)) u_btd (
		.clk(CLK), .srst(SRST), .start(brake_now && BRAKE_DELAY_NEGATIVE),
		.clear(idle_clear), .length(BRAKE_TO_TORQUE_OFF_DELAY),
		.running(), .expired(btd_exp)
	);
	// Brake time to zero, ramp mode only
	estop_timer #(.W(CNT_W)) u_ttz (
		.clk(CLK), .srst(SRST),
		.start(brake_now && (mode_q == estop_pkg::MODE_RAMP)),
		.clear(idle_clear), .length(BRAKE_TIME_TO_ZERO),
		.running(), .expired(ttz_exp)
	);

	// Next state and output decode
	always_comb begin
		state_d    = state_q;
		torque_d   = torque_q;
		brake_d    = brake_q;
		complete_d = complete_q;
		mon_d      = mon_q;
		unique case (state_q)
			estop_pkg::ST_IDLE: begin
				// Mode sampled here and held for the sequence
				if (STOP_REQUEST) begin
					state_d = estop_pkg::ST_RAMP;
				end
			end
			estop_pkg::ST_RAMP: begin
				// Start monitoring with ramping in ramp mode
				if (resp_exp && mode_q == estop_pkg::MODE_RAMP && !below_brake) begin
					mon_d = 1'b1;
				end
				if (resp_exp && below_brake) begin
					mon_d   = 1'b0;
					state_d = estop_pkg::ST_EXTRA;
				end
			end
			estop_pkg::ST_EXTRA: begin
				// Wait out the extra delay, then brake
				if (extra_exp) begin
					brake_d = 1'b1;
					if (!BRAKE_DELAY_NEGATIVE) begin
						torque_d = 1'b1;
					end
					state_d = estop_pkg::ST_BRAKE;
				end
			end
			estop_pkg::ST_BRAKE: begin
				// Deferred torque off
				if (btd_exp) begin
					torque_d = 1'b1;
				end
				if ((mode_q == estop_pkg::MODE_TIME && at_zero) ||
					(mode_q == estop_pkg::MODE_RAMP && ttz_exp)) begin
					complete_d = 1'b1;
					state_d    = estop_pkg::ST_DONE;
				end
			end
			estop_pkg::ST_DONE: begin
				// Wait for a valid acknowledge
				if (btd_exp) begin
					torque_d = 1'b1;
				end
				if (ack_ok) begin
					state_d    = estop_pkg::ST_IDLE;
					torque_d   = 1'b0;
					brake_d    = 1'b0;
					complete_d = 1'b0;
				end
			end
			default: begin
				state_d = estop_pkg::ST_IDLE;
			end
		endcase
		// Forced torque off from timeout or ramp limit
		if (state_q != estop_pkg::ST_IDLE && !ack_ok) begin
			if (mode_q == estop_pkg::MODE_TIME && tmo_exp) begin
				torque_d = 1'b1;
			end
			if (ramp_hit) begin
				torque_d = 1'b1;
			end
		end
		// Completion only from the brake stage, so the brake always runs even when zero speed
		// comes during the extra delay; a deferred torque off is dropped if acknowledged first
		// Monitoring never runs outside ramping
		if (state_d != estop_pkg::ST_RAMP) begin
			mon_d = 1'b0;
		end
	end

	// State registers
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_q    <= estop_pkg::ST_IDLE;
			mode_q     <= estop_pkg::MODE_TIME;
			torque_q   <= 1'b0;
			brake_q    <= 1'b0;
			complete_q <= 1'b0;
			mon_q      <= 1'b0;
			ramp_q     <= 1'b0;
		end else begin
			state_q    <= state_d;
			torque_q   <= torque_d;
			brake_q    <= brake_d;
			complete_q <= complete_d;
			mon_q      <= mon_d;
			// Ramp request follows the response time
			ramp_q     <= resp_exp && (state_d != estop_pkg::ST_IDLE);
			if (start_req) begin
				mode_q <= estop_pkg::mon_mode_t'(RAMP_MODE);
			end
		end
	end

	// Outputs
	assign RAMP_DOWN              = ramp_q;
	assign MODULATION_ALLOWED     = !torque_q;
	assign BRAKE_CONTROL          = brake_q;
	assign TORQUE_OFF             = torque_q;
	assign STOP_ACTIVE_FLAG       = (state_q != estop_pkg::ST_IDLE);
	assign STOP_COMPLETED_FLAG    = complete_q;
	assign TORQUE_OFF_ACTIVE_FLAG = torque_q;
	assign RAMP_MONITOR_ACTIVE    = mon_q;
	assign ACK_ALLOWED            = complete_q && !STOP_REQUEST;

	// Assertions
	a_torque_flag_tracks: assert property (@(posedge CLK) disable iff (SRST)
		TORQUE_OFF_ACTIVE_FLAG == TORQUE_OFF) else $error("torque flag mismatch");
	a_brake_with_torque: assert property (@(posedge CLK) disable iff (SRST)
		brake_now && !BRAKE_DELAY_NEGATIVE |=> BRAKE_CONTROL && TORQUE_OFF)
		else $error("brake and torque not together");
	a_brake_first: assert property (@(posedge CLK) disable iff (SRST)
		brake_now && BRAKE_DELAY_NEGATIVE && BRAKE_TO_TORQUE_OFF_DELAY > CNT_W'(1)
		&& !ramp_hit && !tmo_exp |=> BRAKE_CONTROL && !TORQUE_OFF)
		else $error("torque came with brake");
	a_start_flags: assert property (@(posedge CLK) disable iff (SRST)
		start_req |=> STOP_ACTIVE_FLAG && !STOP_COMPLETED_FLAG)
		else $error("stop not active after request");
	a_timeout_force: assert property (@(posedge CLK) disable iff (SRST)
		STOP_ACTIVE_FLAG && mode_q == estop_pkg::MODE_TIME && tmo_exp && !ack_ok
		|=> TORQUE_OFF) else $error("timeout did not force torque off");
	a_ack_gate: assert property (@(posedge CLK) disable iff (SRST)
		STOP_ACTIVE_FLAG && ACKNOWLEDGE && STOP_REQUEST |=> STOP_ACTIVE_FLAG)
		else $error("acknowledge taken with request present");
	a_ack_clears: assert property (@(posedge CLK) disable iff (SRST)
		ack_ok |=> !STOP_ACTIVE_FLAG && !BRAKE_CONTROL && !TORQUE_OFF
		&& !STOP_COMPLETED_FLAG) else $error("acknowledge did not clear");
	a_ramp_limit: assert property (@(posedge CLK) disable iff (SRST)
		ramp_hit && !ack_ok |=> TORQUE_OFF) else $error("ramp limit ignored");
	a_mon_stops: assert property (@(posedge CLK) disable iff (SRST)
		state_q == estop_pkg::ST_RAMP && resp_exp && below_brake |=> !RAMP_MONITOR_ACTIVE)
		else $error("monitoring not stopped");
	a_mode_hold: assert property (@(posedge CLK) disable iff (SRST)
		STOP_ACTIVE_FLAG && $past(STOP_ACTIVE_FLAG) |-> $stable(mode_q))
		else $error("mode changed in sequence");
	// Stage and timer checks
	a_extra_wait: assert property (@(posedge CLK) disable iff (SRST)
		state_q == estop_pkg::ST_EXTRA && !extra_exp |=> !BRAKE_CONTROL)
		else $error("brake before extra delay");
	a_mon_start: assert property (@(posedge CLK) disable iff (SRST)
		state_q == estop_pkg::ST_RAMP && resp_exp && mode_q == estop_pkg::MODE_RAMP
		&& !below_brake |=> RAMP_MONITOR_ACTIVE) else $error("monitoring not started");
	a_zero_done: assert property (@(posedge CLK) disable iff (SRST)
		state_q == estop_pkg::ST_BRAKE && mode_q == estop_pkg::MODE_TIME && at_zero
		|=> STOP_COMPLETED_FLAG) else $error("zero speed did not complete");
	a_ttz_done: assert property (@(posedge CLK) disable iff (SRST)
		state_q == estop_pkg::ST_BRAKE && mode_q == estop_pkg::MODE_RAMP && ttz_exp
		|=> STOP_COMPLETED_FLAG) else $error("time to zero did not complete");
	a_timers_cleared: assert property (@(posedge CLK) disable iff (SRST)
		ack_ok |=> !resp_exp && !tmo_exp && !extra_exp && !btd_exp && !ttz_exp)
		else $error("timers not cleared at idle");
	c_timeout_force: cover property (@(posedge CLK) disable iff (SRST)
		mode_q == estop_pkg::MODE_TIME && STOP_ACTIVE_FLAG && tmo_exp);
	c_time_complete: cover property (@(posedge CLK) disable iff (SRST)
		mode_q == estop_pkg::MODE_TIME && $rose(STOP_COMPLETED_FLAG));
	c_ramp_complete: cover property (@(posedge CLK) disable iff (SRST)
		mode_q == estop_pkg::MODE_RAMP && $rose(STOP_COMPLETED_FLAG));
	c_brake_first: cover property (@(posedge CLK) disable iff (SRST)
		BRAKE_CONTROL && !TORQUE_OFF ##1 TORQUE_OFF);
	c_ack: cover property (@(posedge CLK) disable iff (SRST) ack_ok);
endmodule : estop_seq

// ==== rtl/estop_timer.sv ====
// Loadable down-counting timer used for every delay of the sequencer
`include "estop_defs.svh"
module estop_timer #(
	parameter int W = `ESTOP_CNT_W
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Control
	input  wire logic         start,
	input  wire logic         clear,
	input  wire logic [W-1:0] length,
	// Status
	output logic              running,
	output logic              expired
);
	// Refuse widths the counter cannot serve
	if (W < 2 || W > 32) begin : g_bad_width
		$error("estop_timer: unsupported width");
	end

	logic [W-1:0] cnt_q;     // Remaining cycles
	logic         run_q;     // Counting
	logic         exp_q;     // Sticky expiry
	logic         hit_zero;  // Last count reached

	assign hit_zero = run_q && (cnt_q <= W'(1));
	assign running  = run_q;
	assign expired  = exp_q;

	// Count down; clear wins over everything
	always_ff @(posedge clk) begin
		if (srst || clear) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			exp_q <= 1'b0;
		end else if (start) begin
			cnt_q <= length;
			run_q <= (length != '0);
			exp_q <= (length == '0);
		end else if (hit_zero) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			exp_q <= 1'b1;
		end else if (run_q) begin
			cnt_q <= cnt_q - W'(1);
		end
	end
endmodule : estop_timer

// ==== verif/drive_model.sv ====
// Behavioural drive that ramps motor speed down while the sequencer asks for it
module drive_model #(
	parameter logic [15:0] TOP_SPEED = 16'h03e8 // Running speed before a stop
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Ramp command and deceleration step per cycle (zero models a stalled ramp)
	input  wire logic        ramp_down,
	input  wire logic [15:0] step,
	// Measured speed
	output logic      [15:0] speed
);
	timeunit 1ns;
	timeprecision 1ps;

	// Speed falls by one step a cycle once ramping starts, floored at zero
	always_ff @(posedge clk) begin
		if (srst || !ramp_down) begin
			speed <= TOP_SPEED; // Modulating at full speed
		end else if (speed > step) begin
			speed <= speed - step; // Deceleration ramp of the first set
		end else begin
			speed <= 16'h0000; // Standstill
		end
	end
endmodule : drive_model

// ==== verif/testbench.sv ====
// Self-checking bench for the emergency stop sequencer with a ramping drive
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk = 1'b0, srst = 1'b1, req = 1'b0, ack = 1'b0, rmode = 1'b0, dneg = 1'b0;
	logic [15:0] blim = 16'h00c8, zlim = 16'h000a, rlo = 16'h0000, rhi = 16'hffff;
	logic [15:0] step = 16'h0014, cur_step = 16'h0014, speed, spd_b, spd_c;
	logic [31:0] tout = 32'h0000_01f4, resp = 32'h0000_0004, extra = 32'h0, dly = 32'h0;
	logic [31:0] btz = 32'h0000_001e;
	logic        rdown, mod_ok, brake, torq, f_act, f_done, f_tq, mon, ack_ok, mon_b;
	int          fails = 0, cmp_count = 0, tb_c, tt_c, tc_c, trd, trm, base;

	// Clock of 5 ns
	initial forever #2.5 clk = ~clk;

	estop_seq dut_u (
		.CLK(clk), .SRST(srst), .STOP_REQUEST(req), .ACKNOWLEDGE(ack), .RAMP_MODE(rmode),
		.BRAKE_SPEED_LIMIT(blim), .ZERO_SPEED_LIMIT(zlim), .STOP_TIMEOUT(tout),
		.RESPONSE_TIME(resp), .EXTRA_ACTIVATION_DELAY(extra), .BRAKE_DELAY_NEGATIVE(dneg),
		.BRAKE_TO_TORQUE_OFF_DELAY(dly), .BRAKE_TIME_TO_ZERO(btz), .MOTOR_SPEED(speed),
		.RAMP_LIMIT_LOW(rlo), .RAMP_LIMIT_HIGH(rhi), .RAMP_DOWN(rdown),
		.MODULATION_ALLOWED(mod_ok), .BRAKE_CONTROL(brake), .TORQUE_OFF(torq),
		.STOP_ACTIVE_FLAG(f_act), .STOP_COMPLETED_FLAG(f_done),
		.TORQUE_OFF_ACTIVE_FLAG(f_tq), .RAMP_MONITOR_ACTIVE(mon), .ACK_ALLOWED(ack_ok)
	);

	drive_model drv_u (.clk(clk), .srst(srst), .ramp_down(rdown), .step(cur_step), .speed(speed));

	// Bit compare
	task automatic check_bit(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %0b, seen %0b", what, exp, got);
		end
	endtask : check_bit

	// Cycle count compare against a window
	task automatic check_win(input string what, input int lo, input int hi, input int got);
		cmp_count++;
		if (got < lo || got > hi) begin
			fails++;
			$display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
		end
	endtask : check_win

	// Inputs change 1 ns after the rising edge
	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick

	// Whole stop sequence: request, watch outputs, refused ack, release, valid ack
	task automatic run_stop(input int stall);
		int n;
		tb_c = -1; tt_c = -1; tc_c = -1; trd = -1; trm = -1;
		cur_step = (stall > 0) ? 16'h0000 : step;
		req = 1'b1;
		tick;
		check_bit("stop active", 1'b1, f_act);
		for (n = 1; n < 3000 && (tc_c < 0 || tt_c < 0); n++) begin
			if (n == stall) cur_step = step;
			check_bit("torque flag", torq, f_tq);
			check_bit("modulation", ~torq, mod_ok);
			if (rdown && trd < 0) trd = n;
			if (mon && trm < 0) trm = n;
			if (brake && tb_c < 0) begin
				tb_c = n;
				mon_b = mon;
				spd_b = speed;
			end
			if (torq && tt_c < 0) tt_c = n;
			if (f_done && tc_c < 0) begin
				tc_c = n;
				spd_c = speed;
			end
			tick;
		end
		check_win("completion seen", 1, 2999, tc_c);
		// Ack while request still high must be ignored
		ack = 1'b1;
		check_bit("ack allowed held", 1'b0, ack_ok);
		tick;
		ack = 1'b0;
		check_bit("completed kept", 1'b1, f_done);
		check_bit("brake kept", 1'b1, brake);
		req = 1'b0;
		tick;
		check_bit("ack allowed", 1'b1, ack_ok);
		ack = 1'b1;
		tick;
		ack = 1'b0;
		tick;
		check_bit("stop active clear", 1'b0, f_act);
		check_bit("completed clear", 1'b0, f_done);
		check_bit("torque flag clear", 1'b0, f_tq);
		check_bit("torque off clear", 1'b0, torq);
		check_bit("brake clear", 1'b0, brake);
		check_bit("modulation back", 1'b1, mod_ok);
	endtask : run_stop

	// Verdict and end of run
	task automatic finish_test;
		if (fails == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	// Watchdog well beyond the thousand or so cycles the tests need
	initial begin
		#100000;
		fails++;
		finish_test;
	end

	// Test sequence
	initial begin
		repeat (3) @(posedge clk);
		#1 srst = 1'b0;
		tick;
		// Time mode, zero delay: brake and torque off together
		run_stop(0);
		base = tb_c;
		check_win("torque with brake", tb_c, tb_c, tt_c);
		check_bit("speed below at brake", 1'b1, spd_b < blim);
		check_bit("zero speed at done", 1'b1, spd_c <= zlim);
		check_win("ramp start", 4, 8, trd);
		// Same setup again starts from cleared counters
		run_stop(0);
		check_win("restart timing", base, base, tb_c);
		// Extra activation delay
		extra = 32'd25;
		run_stop(0);
		check_win("extra delay", base + 24, base + 26, tb_c);
		check_win("extra torque", tb_c, tb_c, tt_c);
		extra = 32'h0;
		// Negative delay: brake first, torque later
		dneg = 1'b1;
		dly = 32'd12;
		run_stop(0);
		check_win("torque after brake", tb_c + 11, tb_c + 13, tt_c);
		dneg = 1'b0;
		dly = 32'h0;
		// Stalled ramp: timeout forces torque off
		run_stop(520);
		check_win("timeout torque", 499, 503, tt_c);
		// Ramp mode, clean ramp
		rmode = 1'b1;
		run_stop(0);
		check_win("monitor start", trd, trd + 1, trm);
		check_bit("monitor off at brake", 1'b0, mon_b);
		check_win("time to zero", tb_c + 29, tb_c + 32, tc_c);
		check_win("ramp torque with brake", tb_c, tb_c, tt_c);
		// Ramp mode, speed above upper ramp limit
		rhi = 16'h0384;
		run_stop(0);
		check_win("limit trip", trm, trm + 2, tt_c);
		check_bit("trip before brake", 1'b1, tt_c < tb_c);
		rhi = 16'hffff;
		rmode = 1'b0;
		finish_test;
	end
endmodule : testbench
